// [core/aaps_regs.vh]
// register offsets, field positions, reset values and operation codes
// of the accumulator datapath; included by every design file of the block
`ifndef AAPS_REGS_VH
`define AAPS_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define AAPS_OFF_PSC 8'h00
`define AAPS_OFF_STAT 8'h04
`define AAPS_OFF_ACC 8'h08

// ****************************************
// pointer_step_control fields and reset
// ****************************************
`define AAPS_PSC_RANGE_MSB 2
`define AAPS_PSC_RANGE_LSB 0
`define AAPS_PSC_DIR_BIT 6
`define AAPS_PSC_RST 8'h00
`define AAPS_RNG_NONE 3'h0
`define AAPS_RNG_STEP_RANGE_BIT2 3'h1
`define AAPS_RNG_MOD4 3'h2
`define AAPS_RNG_MOD8 3'h3
`define AAPS_RNG_MOD16 3'h4

// ****************************************
// status register fields
// ****************************************
`define AAPS_STAT_AP_LSB 0
`define AAPS_STAT_CARRY_BIT 8
`define AAPS_STAT_EQ_BIT 9

// ****************************************
// operation codes from the decoder
// ****************************************
`define AAPS_OP_NOP 6'h00
`define AAPS_OP_ADD 6'h01
`define AAPS_OP_ADDC 6'h02
`define AAPS_OP_SUB 6'h03
`define AAPS_OP_SUBB 6'h04
`define AAPS_OP_CMP 6'h05
`define AAPS_OP_AND 6'h06
`define AAPS_OP_OR 6'h07
`define AAPS_OP_XOR 6'h08
`define AAPS_OP_CPL 6'h09
`define AAPS_OP_NEG 6'h0a
`define AAPS_OP_RL 6'h0b
`define AAPS_OP_RLC 6'h0c
`define AAPS_OP_RR 6'h0d
`define AAPS_OP_RRC 6'h0e
`define AAPS_OP_SLA 6'h0f
`define AAPS_OP_SLA2 6'h10
`define AAPS_OP_SLA4 6'h11
`define AAPS_OP_SRA 6'h12
`define AAPS_OP_SRA2 6'h13
`define AAPS_OP_SRA4 6'h14
`define AAPS_OP_LSR 6'h15
`define AAPS_OP_XCHN 6'h16
`define AAPS_OP_XCH 6'h17
`define AAPS_OP_MOV_IN 6'h18
`define AAPS_OP_MOV_OUT 6'h19
`define AAPS_OP_MOV_RECIRC 6'h1a
`define AAPS_OP_MOV_IDX 6'h1b
`define AAPS_OP_BIT_TO_C 6'h1c
`define AAPS_OP_C_TO_BIT 6'h1d
`define AAPS_OP_BIT_AND 6'h1e
`define AAPS_OP_BIT_OR 6'h1f
`define AAPS_OP_BIT_XOR 6'h20
`define AAPS_OP_SET_C 6'h21
`define AAPS_OP_LOAD_AP 6'h22
`define AAPS_OP_WR_ACC_N 6'h23
`define AAPS_OP_RD_ACC_N 6'h24

`endif

// [core/aaps_ptr_step.v]
// modulo stepper for the 4-bit accumulator pointer
// assumes a decoded range code and direction from the control register
`timescale 1ns/1ns
`include "aaps_regs.vh"

module aaps_ptr_step #(
  parameter PTR_W = 4
) (
  // current pointer and control
  input wire [PTR_W-1:0] ptr_i,
  input wire [2:0] range_i,
  input wire dir_dec_i,
  // stepped pointer
  output reg [PTR_W-1:0] ptr_o
);

  reg [PTR_W-1:0] mask;
  reg [PTR_W-1:0] moved;

  always @* begin
    case (range_i)
      `AAPS_RNG_STEP_RANGE_BIT2: mask = 4'h1;
      `AAPS_RNG_MOD4: mask = 4'h3;
      `AAPS_RNG_MOD8: mask = 4'h7;
      `AAPS_RNG_MOD16: mask = 4'hf;
      default: mask = 4'h0;
    endcase
    moved = dir_dec_i ? ptr_i - 4'h1 : ptr_i + 4'h1;
    // only the masked low bits move, upper bits hold across wrap
    ptr_o = (ptr_i & ~mask) | (moved & mask);
  end

endmodule // aaps_ptr_step

// [core/aaps_core.v]
// accumulator ALU with sixteen accumulators and modulo pointer stepping
// assumes one core clock, a decoder on that clock and a wishbone master
//
// How it works
// - active accumulator indexed by pointer low bits
// - enabled stepping moves pointer after qualifying ops
// - arithmetic, logic, shifts, swaps, acc moves qualify
// - indexed read returns acc, never steps pointer
// - control bits 2:0 choose stepping modulo range
// - control bit 6 set means decrement
// - control register resets to zero, no stepping
// - only selected low pointer bits wrap
// - source ops use acc as operand and destination
// - carry added or borrowed in addc, subb
// - compare sets equals, leaves accumulator alone
// - rotates with and without carry, both ways
// - logical right shift: bit0 to carry, msb zero
// - arithmetic shifts by one, two, four
// - nibble swap per byte, byte swap
// - bit ops on acc bits 0 to 7 with carry
// - bit ops never step the pointer
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "aaps_regs.vh"

module aaps_core #(
  parameter DATA_W = 16,
  parameter PTR_W = 4,
  parameter NUM_ACC = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // decoder operation port
  input wire op_valid_i,
  input wire [5:0] op_code_i,
  input wire [DATA_W-1:0] src_i,
  input wire [2:0] bit_sel_i,
  input wire [PTR_W-1:0] acc_idx_i,
  // results and flags
  output reg [DATA_W-1:0] result_o,
  output reg result_valid_o,
  output reg [DATA_W-1:0] active_acc_o,
  output reg [PTR_W-1:0] acc_pointer_o,
  output reg carry_o,
  output reg equals_o
);

  // ****************************************
  // state
  // ****************************************
  reg [DATA_W-1:0] acc_mem [0:NUM_ACC-1];
  reg [PTR_W-1:0] acc_pointer_ff;
  reg [2:0] step_range_ff;
  reg step_direction_select_ff;
  reg carry_ff;
  reg equals_ff;
  integer i;

  wire [DATA_W-1:0] cur_acc;
  wire [PTR_W-1:0] stepped_ptr;
  wire [7:0] psc_view;

  assign cur_acc = acc_mem[acc_pointer_ff];
  assign psc_view = {1'b0, step_direction_select_ff, 3'h0, step_range_ff};

  // ****************************************
  // pointer stepper
  // ****************************************
  aaps_ptr_step #(
    .PTR_W(PTR_W)
  ) u_step (
    .ptr_i(acc_pointer_ff),
    .range_i(step_range_ff),
    .dir_dec_i(step_direction_select_ff),
    .ptr_o(stepped_ptr)
  );

  // ****************************************
  // alu next-state
  // ****************************************
  reg acc_we;
  reg [PTR_W-1:0] acc_widx;
  reg [DATA_W-1:0] acc_wdata;
  reg qualify;
  reg nxt_carry;
  reg nxt_equals;
  reg [PTR_W-1:0] nxt_ap;
  reg out_we;
  reg [DATA_W-1:0] out_data;
  reg [DATA_W:0] wide;
  reg [DATA_W-1:0] bitmask;
  reg sel_bit;

  always @* begin
    acc_we = 1'b0;
    acc_widx = acc_pointer_ff;
    acc_wdata = cur_acc;
    qualify = 1'b0;
    nxt_carry = carry_ff;
    nxt_equals = equals_ff;
    out_we = 1'b0;
    out_data = result_o;
    wide = {1'b0, cur_acc};
    // bit ops reach only bits 0 to 7 of the accumulator
    bitmask = 16'h0001 << bit_sel_i;
    sel_bit = cur_acc[bit_sel_i];
    if (op_valid_i) begin
      case (op_code_i)
        `AAPS_OP_ADD: begin
          wide = {1'b0, cur_acc} + {1'b0, src_i};
          acc_we = 1'b1;
          acc_wdata = wide[DATA_W-1:0];
          nxt_carry = wide[DATA_W];
          qualify = 1'b1;
        end
        `AAPS_OP_ADDC: begin
          wide = {1'b0, cur_acc} + {1'b0, src_i} + {16'h0000, carry_ff};
          acc_we = 1'b1;
          acc_wdata = wide[DATA_W-1:0];
          nxt_carry = wide[DATA_W];
          qualify = 1'b1;
        end
        `AAPS_OP_SUB: begin
          wide = {1'b0, cur_acc} - {1'b0, src_i};
          acc_we = 1'b1;
          acc_wdata = wide[DATA_W-1:0];
          nxt_carry = wide[DATA_W];
          qualify = 1'b1;
        end
        `AAPS_OP_SUBB: begin
          wide = {1'b0, cur_acc} - {1'b0, src_i} - {16'h0000, carry_ff};
          acc_we = 1'b1;
          acc_wdata = wide[DATA_W-1:0];
          nxt_carry = wide[DATA_W];
          qualify = 1'b1;
        end
        `AAPS_OP_CMP: begin
          // compare touches only the equals flag and does not step
          nxt_equals = (cur_acc == src_i);
        end
        `AAPS_OP_AND: begin
          acc_we = 1'b1;
          acc_wdata = cur_acc & src_i;
          qualify = 1'b1;
        end
        `AAPS_OP_OR: begin
          acc_we = 1'b1;
          acc_wdata = cur_acc | src_i;
          qualify = 1'b1;
        end
        `AAPS_OP_XOR: begin
          acc_we = 1'b1;
          acc_wdata = cur_acc ^ src_i;
          qualify = 1'b1;
        end
        `AAPS_OP_CPL: begin
          acc_we = 1'b1;
          acc_wdata = ~cur_acc;
          qualify = 1'b1;
        end
        `AAPS_OP_NEG: begin
          acc_we = 1'b1;
          acc_wdata = ~cur_acc + 16'h0001;
          qualify = 1'b1;
        end
        `AAPS_OP_RL: begin
          acc_we = 1'b1;
          acc_wdata = {cur_acc[14:0], cur_acc[15]};
          qualify = 1'b1;
        end
        `AAPS_OP_RLC: begin
          acc_we = 1'b1;
          acc_wdata = {cur_acc[14:0], carry_ff};
          nxt_carry = cur_acc[15];
          qualify = 1'b1;
        end
        `AAPS_OP_RR: begin
          acc_we = 1'b1;
          acc_wdata = {cur_acc[0], cur_acc[15:1]};
          qualify = 1'b1;
        end
        `AAPS_OP_RRC: begin
          acc_we = 1'b1;
          acc_wdata = {carry_ff, cur_acc[15:1]};
          nxt_carry = cur_acc[0];
          qualify = 1'b1;
        end
        `AAPS_OP_SLA: begin
          acc_we = 1'b1;
          acc_wdata = {cur_acc[14:0], 1'b0};
          nxt_carry = cur_acc[15];
          qualify = 1'b1;
        end
        `AAPS_OP_SLA2: begin
          acc_we = 1'b1;
          acc_wdata = {cur_acc[13:0], 2'h0};
          nxt_carry = cur_acc[14];
          qualify = 1'b1;
        end
        `AAPS_OP_SLA4: begin
          acc_we = 1'b1;
          acc_wdata = {cur_acc[11:0], 4'h0};
          nxt_carry = cur_acc[12];
          qualify = 1'b1;
        end
        `AAPS_OP_SRA: begin
          acc_we = 1'b1;
          acc_wdata = {cur_acc[15], cur_acc[15:1]};
          nxt_carry = cur_acc[0];
          qualify = 1'b1;
        end
        `AAPS_OP_SRA2: begin
          acc_we = 1'b1;
          acc_wdata = {{2{cur_acc[15]}}, cur_acc[15:2]};
          nxt_carry = cur_acc[1];
          qualify = 1'b1;
        end
        `AAPS_OP_SRA4: begin
          acc_we = 1'b1;
          acc_wdata = {{4{cur_acc[15]}}, cur_acc[15:4]};
          nxt_carry = cur_acc[3];
          qualify = 1'b1;
        end
        `AAPS_OP_LSR: begin
          acc_we = 1'b1;
          acc_wdata = {1'b0, cur_acc[15:1]};
          nxt_carry = cur_acc[0];
          qualify = 1'b1;
        end
        `AAPS_OP_XCHN: begin
          acc_we = 1'b1;
          acc_wdata = {cur_acc[11:8], cur_acc[15:12],
                       cur_acc[3:0], cur_acc[7:4]};
          qualify = 1'b1;
        end
        `AAPS_OP_XCH: begin
          acc_we = 1'b1;
          acc_wdata = {cur_acc[7:0], cur_acc[15:8]};
          qualify = 1'b1;
        end
        `AAPS_OP_MOV_IN: begin
          // src_i is never the active accumulator here
          acc_we = 1'b1;
          acc_wdata = src_i;
          qualify = 1'b1;
        end
        `AAPS_OP_MOV_OUT: begin
          out_we = 1'b1;
          out_data = cur_acc;
          qualify = 1'b1;
        end
        `AAPS_OP_MOV_RECIRC: begin
          acc_we = 1'b1;
          acc_wdata = cur_acc;
          qualify = 1'b1;
        end
        `AAPS_OP_MOV_IDX: begin
          // same value as the plain read but the pointer stays put
          out_we = 1'b1;
          out_data = cur_acc;
        end
        `AAPS_OP_BIT_TO_C: begin
          nxt_carry = sel_bit;
        end
        `AAPS_OP_C_TO_BIT: begin
          acc_we = 1'b1;
          acc_wdata = carry_ff ? (cur_acc | bitmask) : (cur_acc & ~bitmask);
        end
        `AAPS_OP_BIT_AND: begin
          acc_we = 1'b1;
          acc_wdata = (sel_bit & carry_ff) ? cur_acc : (cur_acc & ~bitmask);
        end
        `AAPS_OP_BIT_OR: begin
          acc_we = 1'b1;
          acc_wdata = (sel_bit | carry_ff) ? (cur_acc | bitmask) : cur_acc;
        end
        `AAPS_OP_BIT_XOR: begin
          acc_we = 1'b1;
          acc_wdata = (sel_bit ^ carry_ff) ? (cur_acc | bitmask)
                                           : (cur_acc & ~bitmask);
        end
        `AAPS_OP_SET_C: begin
          nxt_carry = bit_sel_i[0];
        end
        `AAPS_OP_WR_ACC_N: begin
          acc_we = 1'b1;
          acc_widx = acc_idx_i;
          acc_wdata = src_i;
        end
        `AAPS_OP_RD_ACC_N: begin
          out_we = 1'b1;
          out_data = acc_mem[acc_idx_i];
        end
        default: begin
          acc_we = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // pointer and shadow of the next active value
  // ****************************************
  reg [DATA_W-1:0] nxt_active;

  always @* begin
    if (op_valid_i && op_code_i == `AAPS_OP_LOAD_AP) begin
      nxt_ap = src_i[PTR_W-1:0];
    end else if (qualify) begin
      // range code 000 or an unused code leaves the pointer where it is
      nxt_ap = stepped_ptr;
    end else begin
      nxt_ap = acc_pointer_ff;
    end
    // the write lands in the old slot, the new pointer shows next cycle
    if (acc_we && acc_widx == nxt_ap) begin
      nxt_active = acc_wdata;
    end else begin
      nxt_active = acc_mem[nxt_ap];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < NUM_ACC; i = i + 1) begin
        acc_mem[i] <= 16'h0000;
      end
    end else if (acc_we) begin
      acc_mem[acc_widx] <= acc_wdata;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_pointer_ff <= 4'h0;
      carry_ff <= 1'b0;
      equals_ff <= 1'b0;
      result_o <= 16'h0000;
      result_valid_o <= 1'b0;
      active_acc_o <= 16'h0000;
      acc_pointer_o <= 4'h0;
      carry_o <= 1'b0;
      equals_o <= 1'b0;
    end else begin
      acc_pointer_ff <= nxt_ap;
      carry_ff <= nxt_carry;
      equals_ff <= nxt_equals;
      result_o <= out_data;
      result_valid_o <= out_we;
      active_acc_o <= nxt_active;
      acc_pointer_o <= nxt_ap;
      carry_o <= nxt_carry;
      equals_o <= nxt_equals;
    end
  end

  // ****************************************
  // wishbone register slave
  // ****************************************
  wire wb_req;
  reg [31:0] nxt_rdata;

  // one-cycle answer; ack held low in the cycle after it to end the beat
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always @* begin
    case (wb_adr_i)
      `AAPS_OFF_PSC: nxt_rdata = {24'h000000, psc_view};
      `AAPS_OFF_STAT: nxt_rdata = {22'h000000, equals_ff, carry_ff,
                                   4'h0, acc_pointer_ff};
      `AAPS_OFF_ACC: nxt_rdata = {16'h0000, cur_acc};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      step_range_ff <= `AAPS_RNG_NONE;
      step_direction_select_ff <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= nxt_rdata;
      end
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `AAPS_OFF_PSC) begin
        step_range_ff <= wb_dat_i[`AAPS_PSC_RANGE_MSB:`AAPS_PSC_RANGE_LSB];
        step_direction_select_ff <= wb_dat_i[`AAPS_PSC_DIR_BIT];
      end
    end
  end

endmodule // aaps_core

// [test/aaps_step_fn.svh]
// pointer after one modulo step under a given control byte
// included inside a module body, so it carries no guard
function [3:0] step_ptr(input [3:0] p, input [7:0] c);
  reg [3:0] d;
  begin
    d = c[6] ? 4'hf : 4'h1;
    case (c[2:0])
      3'h1: step_ptr = {p[3:1], p[0] ^ d[0]};
      3'h2: step_ptr = {p[3:2], p[1:0] + d[1:0]};
      3'h3: step_ptr = {p[3], p[2:0] + d[2:0]};
      3'h4: step_ptr = p + d;
      default: step_ptr = p;
    endcase
  end
endfunction

// [test/aaps_chk.sv]
// concurrent checks on the ports of the accumulator datapath
// assumes bus writes and decoder ops never land on the same edge
`timescale 1ns/1ns
`include "aaps_regs.vh"

module aaps_chk #(
  parameter DATA_W = 16,
  parameter PTR_W = 4
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // decoder port and state
  input wire op_valid_i,
  input wire [5:0] op_code_i,
  input wire [DATA_W-1:0] src_i,
  input wire [DATA_W-1:0] result_o,
  input wire result_valid_o,
  input wire [DATA_W-1:0] active_acc_o,
  input wire [PTR_W-1:0] acc_pointer_o,
  input wire carry_o,
  input wire equals_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  `include "aaps_step_fn.svh"
  // ****************************************
  // shadow of the step control, taken when the slave takes the write
  // ****************************************
  reg [7:0] ctl_ff;
  always @(posedge clk_i) begin
    if (rst_i)
      ctl_ff <= 8'h00;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0])
      ctl_ff <= wb_dat_i[7:0];
  end
  wire is_op_qual = op_valid_i && op_code_i >= `AAPS_OP_ADD &&
    op_code_i <= `AAPS_OP_MOV_RECIRC && op_code_i != `AAPS_OP_CMP;
  wire is_op_bit = op_valid_i && op_code_i >= `AAPS_OP_BIT_TO_C && op_code_i <= `AAPS_OP_SET_C;
  // without stepping the same accumulator stays visible on active_acc_o
  wire no_step = ctl_ff[2:0] == 3'h0 || ctl_ff[2:0] > 3'h4;
  wire is_add = op_valid_i && op_code_i == `AAPS_OP_ADD && no_step;
  wire is_lsr = op_valid_i && op_code_i == `AAPS_OP_LSR && no_step;
  wire is_xch = op_valid_i && op_code_i == `AAPS_OP_XCH && no_step;
  wire is_neg = op_valid_i && op_code_i == `AAPS_OP_NEG && no_step;
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_ptr_kept;
    $stable(acc_pointer_o);
  endsequence
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  property p_step;
    is_op_qual |=> acc_pointer_o == step_ptr($past(acc_pointer_o), $past(ctl_ff));
  endproperty
  a_step: assert property (p_step) else $error("pointer step wrong");
  property p_idx;
    op_valid_i && op_code_i == `AAPS_OP_MOV_IDX |=>
      s_ptr_kept and (result_valid_o && result_o == $past(active_acc_o));
  endproperty
  a_idx: assert property (p_idx) else $error("indexed read wrong");
  property p_bit;
    is_op_bit |=> s_ptr_kept;
  endproperty
  a_bit: assert property (p_bit) else $error("bit op moved pointer");
  property p_cmp;
    op_valid_i && op_code_i == `AAPS_OP_CMP |=>
      equals_o == ($past(active_acc_o) == $past(src_i)) && $stable(active_acc_o);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrong");
  property p_add;
    is_add |=> {carry_o, active_acc_o} == {1'b0, $past(active_acc_o)} + {1'b0, $past(src_i)};
  endproperty
  a_add: assert property (p_add) else $error("add wrong");
  property p_lsr;
    is_lsr |=> {active_acc_o, carry_o} == {1'b0, $past(active_acc_o)};
  endproperty
  a_lsr: assert property (p_lsr) else $error("logical right shift wrong");
  property p_xch;
    is_xch |=> active_acc_o == 16'({$past(active_acc_o), $past(active_acc_o)} >> 8);
  endproperty
  a_xch: assert property (p_xch) else $error("byte swap wrong");
  property p_neg;
    is_neg |=> active_acc_o == 16'h0000 - $past(active_acc_o);
  endproperty
  a_neg: assert property (p_neg) else $error("negate wrong");
endmodule // aaps_chk

bind aaps_core aaps_chk #(.DATA_W(DATA_W), .PTR_W(PTR_W)) u_aaps_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .op_valid_i, .op_code_i, .src_i, .result_o, .result_valid_o,
  .active_acc_o, .acc_pointer_o, .carry_o, .equals_o
);

// [test/aaps_dec_model.sv]
// decoder stand-in: issues one operation per call, then idles a cycle
// assumes one caller at a time, from the bench's main process
`timescale 1ns/1ns

module aaps_dec_model (
  // clock
  input wire clk_i,
  // operation port
  output reg op_valid_o,
  output reg [5:0] op_code_o,
  output reg [15:0] src_o,
  output reg [2:0] bit_sel_o,
  output reg [3:0] acc_idx_o
);
  initial begin
    op_valid_o = 1'b0;
    op_code_o = 6'h00;
    src_o = 16'h0000;
    bit_sel_o = 3'h0;
    acc_idx_o = 4'h0;
  end
  // sources are plain values and indexed reads go out on result_o only
  task issue(input [5:0] c, input [15:0] s, input [2:0] b, input [3:0] x);
    begin
      @(posedge clk_i);
      op_valid_o <= 1'b1;
      op_code_o <= c;
      src_o <= s;
      bit_sel_o <= b;
      acc_idx_o <= x;
      @(posedge clk_i);
      op_valid_o <= 1'b0;
      // a stale operand must not look live while idle
      src_o <= ~s;
    end
  endtask
endmodule // aaps_dec_model

// [test/tb_top.sv]
// self-checking bench for the accumulator datapath
// assumes the design, the bound checker and the decoder model are compiled first
`timescale 1ns/1ns
`include "aaps_regs.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc = 1'b0;
  reg wb_stb = 1'b0;
  reg wb_we = 1'b0;
  reg [7:0] wb_adr = 8'h00;
  reg [3:0] wb_sel = 4'h0;
  reg [31:0] wb_wdat = 32'h0;
  reg [31:0] q;
  reg [3:0] ep;
  wire [31:0] wb_rdat;
  wire wb_ack, op_v, res_v, c_o, e_o;
  wire [5:0] op_c;
  wire [15:0] src, res, acc;
  wire [2:0] bsel;
  wire [3:0] idx, ptr;
  integer num_errors = 0;
  integer compares = 0;
  integer i, j, k;
  `include "aaps_step_fn.svh"
  always #2 clk_i = ~clk_i;
  aaps_core u_aaps_core (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .op_valid_i(op_v), .op_code_i(op_c), .src_i(src), .bit_sel_i(bsel),
    .acc_idx_i(idx), .result_o(res), .result_valid_o(res_v), .active_acc_o(acc),
    .acc_pointer_o(ptr), .carry_o(c_o), .equals_o(e_o)
  );
  aaps_dec_model u_aaps_dec_model (
    .clk_i(clk_i), .op_valid_o(op_v), .op_code_o(op_c), .src_o(src), .bit_sel_o(bsel),
    .acc_idx_o(idx)
  );
  // ****************************************
  // access tasks
  // ****************************************
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= 4'h1;
      @(posedge clk_i);
      // only the watchdog ends a wait for ack
      while (wb_ack !== 1'b1) begin
        @(posedge clk_i);
      end
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
    end
  endtask
  // state is looked at mid-cycle, after the taking edge has settled
  task op(input [5:0] c, input [15:0] s, input [2:0] b, input [3:0] x);
    begin
      u_aaps_dec_model.issue(c, s, b, x);
      @(negedge clk_i);
    end
  endtask
  // k above 1 means the carry is left unchecked
  task row(input [5:0] c, input [15:0] s, input [2:0] b, input [15:0] a, input [1:0] k);
    begin
      op(c, s, b, 4'h0);
      `CHK("acc", a, acc)
      if (k < 2) `CHK("carry", k[0], c_o)
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #20000;
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `AAPS_OFF_PSC, 0);
    `CHK("psc reset", 32'h0, q)
    wb(1, `AAPS_OFF_PSC, 32'hff);
    wb(0, `AAPS_OFF_PSC, 0);
    `CHK("psc bits", 32'h47, q)
    wb(1, `AAPS_OFF_STAT, 32'h3ff);
    wb(0, `AAPS_OFF_STAT, 0);
    `CHK("status ro", 32'h0, q)
    wb(0, 8'h0c, 0);
    `CHK("unmapped", 32'h0, q)
    $display("test registers done");
    op(`AAPS_OP_LOAD_AP, 16'h2, 0, 0);
    wb(1, `AAPS_OFF_PSC, 32'h02);
    for (i = 1; i < 6; i++) begin
      op(`AAPS_OP_ADD, 16'(i), 0, 0);
      `CHK("ptr", 4'((i + 2) % 4), ptr)
    end
    for (k = 0; k < 4; k++) begin
      op(`AAPS_OP_RD_ACC_N, 0, 0, 4'(k));
      `CHK("acc n", 16'({16'h2, 16'h6, 16'h4, 16'h3} >> (16 * k)), res)
    end
    $display("test example done");
    for (i = 0; i < 8; i++) begin
      k = ((i % 2) << 6) | (i / 2 + 1);
      wb(1, `AAPS_OFF_PSC, 32'(k));
      for (j = 0; j < 2; j++) begin
        op(`AAPS_OP_LOAD_AP, 16'(j * 15), 0, 0);
        op(`AAPS_OP_CPL, 0, 0, 0);
        `CHK("step", step_ptr(4'(j * 15), 8'(k)), ptr)
      end
    end
    $display("test modes done");
    wb(1, `AAPS_OFF_PSC, 32'h04);
    op(`AAPS_OP_LOAD_AP, 0, 0, 0);
    ep = 4'h0;
    for (i = 0; i < 38; i++) begin
      if (i != `AAPS_OP_LOAD_AP) begin
        op(6'(i), 16'h0001, 3'h0, 4'h0);
        if (i >= 1 && i <= 26 && i != 5)
          ep = ep + 4'h1;
        `CHK("qualify", ep, ptr)
      end
    end
    $display("test qualifying done");
    wb(1, `AAPS_OFF_PSC, 32'h00);
    row(`AAPS_OP_MOV_IN, 16'h8001, 0, 16'h8001, 2);
    row(`AAPS_OP_ADD, 16'h8000, 0, 16'h0001, 1);
    row(`AAPS_OP_ADDC, 16'h0001, 0, 16'h0003, 0);
    row(`AAPS_OP_SUB, 16'h0004, 0, 16'hffff, 1);
    row(`AAPS_OP_SUBB, 16'h0000, 0, 16'hfffe, 0);
    row(`AAPS_OP_NEG, 0, 0, 16'h0002, 2);
    row(`AAPS_OP_CPL, 0, 0, 16'hfffd, 2);
    row(`AAPS_OP_LSR, 0, 0, 16'h7ffe, 1);
    row(`AAPS_OP_RRC, 0, 0, 16'hbfff, 0);
    row(`AAPS_OP_XCHN, 0, 0, 16'hfbff, 2);
    row(`AAPS_OP_XCH, 0, 0, 16'hfffb, 2);
    row(`AAPS_OP_RL, 0, 0, 16'hfff7, 0);
    row(`AAPS_OP_RR, 0, 0, 16'hfffb, 2);
    row(`AAPS_OP_RLC, 0, 0, 16'hfff6, 1);
    row(`AAPS_OP_SLA4, 0, 0, 16'hff60, 1);
    row(`AAPS_OP_SRA2, 0, 0, 16'hffd8, 0);
    row(`AAPS_OP_AND, 16'h0f0f, 0, 16'h0f08, 2);
    row(`AAPS_OP_OR, 16'h0030, 0, 16'h0f38, 2);
    row(`AAPS_OP_XOR, 16'h0f00, 0, 16'h0038, 2);
    row(`AAPS_OP_SET_C, 0, 1, 16'h0038, 1);
    row(`AAPS_OP_C_TO_BIT, 0, 7, 16'h00b8, 1);
    row(`AAPS_OP_BIT_TO_C, 0, 0, 16'h00b8, 0);
    row(`AAPS_OP_BIT_AND, 0, 7, 16'h0038, 0);
    row(`AAPS_OP_SET_C, 0, 1, 16'h0038, 1);
    row(`AAPS_OP_BIT_OR, 0, 0, 16'h0039, 1);
    row(`AAPS_OP_BIT_XOR, 0, 3, 16'h0031, 1);
    row(`AAPS_OP_CMP, 16'h0031, 0, 16'h0031, 2);
    `CHK("equals", 1'b1, e_o)
    row(`AAPS_OP_CMP, 16'h0030, 0, 16'h0031, 2);
    `CHK("equals", 1'b0, e_o)
    row(`AAPS_OP_MOV_IN, 16'h8003, 0, 16'h8003, 2);
    row(`AAPS_OP_SRA, 0, 0, 16'hc001, 1);
    row(`AAPS_OP_SRA4, 0, 0, 16'hfc00, 0);
    row(`AAPS_OP_SLA, 0, 0, 16'hf800, 1);
    row(`AAPS_OP_SLA2, 0, 0, 16'he000, 1);
    row(`AAPS_OP_MOV_OUT, 0, 0, 16'he000, 2);
    `CHK("mov out", 16'he000, res)
    `CHK("res valid", 1'b1, res_v)
    op(`AAPS_OP_WR_ACC_N, 16'h1234, 0, 4'h5);
    op(`AAPS_OP_RD_ACC_N, 0, 0, 4'h5);
    `CHK("acc n", 16'h1234, res)
    $display("test alu done");
    complete_run;
  end
endmodule // tb_top
